// ===== design/i2c_address_and_baud_register.sv
// Address, baud divider and data buffer part of the serial port, with FIFO
// Contract
// - Master clock period is 4*(divider+1) cycles
// - High address byte upper bits must be 11110
// - High byte uses register bits 2:1, bit0 ignored
// - Low address byte compares all eight bits
// - Seven-bit mode: bits 7:1 are address
// - Data buffer readable, writable, kept across resets
// - Dedicated pins ignore input level selection
// - Only mask-one bits take part in matching, except high-byte bits 7:3, always checked against 11110
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Synchronous FIFO with valid and ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt; // Write pointer
  logic [AW-1:0] rd_ptr_r, rd_ptr_nxt; // Read pointer
  logic [AW:0] count_r, count_nxt; // Words held
  logic push, pop; // Accepted transfers
  // Handshakes follow occupancy
  assign in_ready_out = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem[rd_ptr_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // Next pointer and count values
  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  // Register pointers and count
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (ce_in) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end
  // Memory write, no reset on storage
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end
endmodule : byte_fifo
// Top of the block
module i2c_address_and_baud_register (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  output logic scl_sync_out,
  output logic sda_sync_out,
  output logic scl_o_out,
  output logic scl_oe_out,
  output logic [1:0] level_select_out,
  input wire logic addr_valid_in,
  input wire logic [7:0] addr_byte_in,
  input wire logic addr_low_phase_in,
  output logic match_valid_out,
  output logic match_out,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic [7:0] rx_data_in,
  output logic tx_load_out,
  output logic [7:0] tx_data_out
);
  // Registers
  logic [7:0] divider_r, divider_nxt; // Address or baud divider
  logic [7:0] mask_r, mask_nxt; // Address mask
  logic [7:0] control_r, control_nxt; // Mode control
  logic [1:0] level_r, level_nxt; // Input level selection
  logic [7:0] data_buffer_r, data_buffer_nxt; // Data buffer, never reset
  logic buf_full_r, buf_full_nxt; // Received byte waiting
  logic [7:0] rdata_r, rdata_nxt; // Read data
  // Baud generator
  logic [8:0] baud_cnt_r, baud_cnt_nxt; // Half period down counter
  logic scl_r, scl_nxt; // Generated clock level
  // Matcher
  logic match_r, match_nxt; // Registered match
  logic match_valid_r, match_valid_nxt; // Match result strobe
  logic tx_load_r, tx_load_nxt; // Buffer written by software
  // Pin synchronisers
  logic scl_meta_r, scl_sync_r, sda_meta_r, sda_sync_r;
  // FIFO drain side
  logic fifo_valid, fifo_ready;
  logic [7:0] fifo_data;
  logic is_master, is_ten, is_dedicated; // Control decode
  logic [8:0] half_reload; // Reload value of the half period
  // Address compare of one received byte
  function automatic logic addr_match(input logic [7:0] rx,
                                      input logic low_phase,
                                      input logic ten,
                                      input logic [7:0] own,
                                      input logic [7:0] msk);
    logic [7:0] diff;
    diff = (rx ^ own) & msk; // Mask-zero bits drop out
    if (!ten) begin
      addr_match = (diff[7:1] == 7'h00); // Bit 0 unused
    end else if (!low_phase) begin
      addr_match = (rx[7:3] == i2c_addr_baud_pkg::TEN_BIT_PATTERN)
                   && (diff[2:1] == 2'h0);
    end else begin
      addr_match = (diff == 8'h00);
    end
  endfunction : addr_match
  assign is_master = control_r[i2c_addr_baud_pkg::CTRL_MASTER_BIT];
  assign is_ten = control_r[i2c_addr_baud_pkg::CTRL_TEN_BIT];
  assign is_dedicated = control_r[i2c_addr_baud_pkg::CTRL_DEDICATED_BIT];
  // Each half lasts 2*(divider+1) cycles: counter runs 2*divider+1 to 0
  assign half_reload = {divider_r, 1'b1};
  assign fifo_ready = !buf_full_r;
  // Received bytes wait in the FIFO until the buffer is free
  byte_fifo #(
    .WIDTH(i2c_addr_baud_pkg::FIFO_WIDTH),
    .DEPTH(i2c_addr_baud_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_valid_in(rx_valid_in),
    .in_ready_out(rx_ready_out),
    .in_data_in(rx_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_ready),
    .out_data_out(fifo_data)
  );
  // Register file next values, buffer load and read mux
  always_comb begin
    divider_nxt = divider_r;
    mask_nxt = mask_r;
    control_nxt = control_r;
    level_nxt = level_r;
    data_buffer_nxt = data_buffer_r;
    buf_full_nxt = buf_full_r;
    tx_load_nxt = 1'b0;
    rdata_nxt = 8'h00;
    // Reading the buffer frees it
    if (reg_rd_in && reg_addr_in == i2c_addr_baud_pkg::DATA_BUFFER_OFS) begin
      buf_full_nxt = 1'b0;
    end
    // Free buffer takes the next received byte
    if (fifo_valid && fifo_ready) begin
      data_buffer_nxt = fifo_data;
      buf_full_nxt = 1'b1;
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        i2c_addr_baud_pkg::ADDR_DIVIDER_OFS: divider_nxt = reg_wdata_in;
        i2c_addr_baud_pkg::ADDRESS_MASK_OFS: mask_nxt = reg_wdata_in;
        i2c_addr_baud_pkg::PORT_CONTROL_OFS: control_nxt = reg_wdata_in;
        i2c_addr_baud_pkg::LEVEL_SELECT_OFS: level_nxt = reg_wdata_in[1:0];
        i2c_addr_baud_pkg::DATA_BUFFER_OFS: begin
          data_buffer_nxt = reg_wdata_in;
          tx_load_nxt = 1'b1;
        end
        default: ; // Unmapped writes are dropped
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        i2c_addr_baud_pkg::ADDR_DIVIDER_OFS: rdata_nxt = divider_r;
        i2c_addr_baud_pkg::ADDRESS_MASK_OFS: rdata_nxt = mask_r;
        i2c_addr_baud_pkg::PORT_CONTROL_OFS: rdata_nxt = control_r;
        i2c_addr_baud_pkg::LEVEL_SELECT_OFS: rdata_nxt = {6'h00, level_r};
        i2c_addr_baud_pkg::DATA_BUFFER_OFS: rdata_nxt = data_buffer_r;
        i2c_addr_baud_pkg::PORT_STATUS_OFS: begin
          rdata_nxt[i2c_addr_baud_pkg::STAT_BUF_FULL_BIT] = buf_full_r;
          rdata_nxt[i2c_addr_baud_pkg::STAT_MATCH_BIT] = match_r;
          rdata_nxt[i2c_addr_baud_pkg::STAT_FIFO_FULL_BIT] = !rx_ready_out;
          rdata_nxt[i2c_addr_baud_pkg::STAT_SCL_BIT] = scl_r;
        end
        default: rdata_nxt = 8'h00; // Unmapped reads give zero
      endcase
    end
  end
  // Register file state; the data buffer keeps its value over reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      divider_r <= i2c_addr_baud_pkg::ADDR_DIVIDER_RST;
      mask_r <= i2c_addr_baud_pkg::ADDRESS_MASK_RST;
      control_r <= i2c_addr_baud_pkg::PORT_CONTROL_RST;
      level_r <= i2c_addr_baud_pkg::LEVEL_SELECT_RST;
      buf_full_r <= 1'b0;
      tx_load_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce_in) begin
      divider_r <= divider_nxt;
      mask_r <= mask_nxt;
      control_r <= control_nxt;
      level_r <= level_nxt;
      buf_full_r <= buf_full_nxt;
      tx_load_r <= tx_load_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  // Buffer register, untouched by reset
  always_ff @(posedge sys_clk_in) begin
    if (ce_in) begin
      data_buffer_r <= data_buffer_nxt;
    end
  end
  // Baud divider next state
  always_comb begin
    baud_cnt_nxt = baud_cnt_r;
    scl_nxt = scl_r;
    if (!is_master) begin
      baud_cnt_nxt = half_reload; // Idle: clock released high
      scl_nxt = 1'b1;
    end else if (baud_cnt_r == 9'h000) begin
      baud_cnt_nxt = half_reload;
      scl_nxt = !scl_r;
    end else begin
      baud_cnt_nxt = baud_cnt_r - 9'h001;
    end
  end
  // Baud divider state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      baud_cnt_r <= 9'h000;
      scl_r <= 1'b1;
    end else if (ce_in) begin
      baud_cnt_r <= baud_cnt_nxt;
      scl_r <= scl_nxt;
    end
  end
  // Address matcher next state
  always_comb begin
    match_valid_nxt = addr_valid_in && !is_master;
    match_nxt = match_r;
    if (addr_valid_in && !is_master) begin
      match_nxt = addr_match(addr_byte_in, addr_low_phase_in, is_ten,
                             divider_r, mask_r);
    end
  end
  // Address matcher state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      match_r <= 1'b0;
      match_valid_r <= 1'b0;
    end else if (ce_in) begin
      match_r <= match_nxt;
      match_valid_r <= match_valid_nxt;
    end
  end
  // Two-stage synchronisers on the bus pins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else if (ce_in) begin
      scl_meta_r <= scl_pin_in;
      scl_sync_r <= scl_meta_r;
      sda_meta_r <= sda_pin_in;
      sda_sync_r <= sda_meta_r;
    end
  end
  // Outputs
  assign reg_rdata_out = rdata_r;
  assign scl_sync_out = scl_sync_r;
  assign sda_sync_out = sda_sync_r;
  assign scl_o_out = 1'b0; // Open drain: only ever pulls low
  assign scl_oe_out = is_master && !scl_r;
  assign level_select_out = is_dedicated ? 2'h0 : level_r;
  assign match_valid_out = match_valid_r;
  assign match_out = match_r;
  assign tx_load_out = tx_load_r;
  assign tx_data_out = data_buffer_r;
  // Checks
  a_scl_half_end: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && is_master && baud_cnt_r == 9'h000) |=> (scl_r != $past(scl_r)))
    else $error("Clock did not toggle at end of half");
  a_baud_reload: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && is_master && baud_cnt_r == 9'h000)
      |=> (baud_cnt_r == {$past(divider_r), 1'b1}))
    else $error("Divider reload value wrong");
  a_hi_pattern: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && addr_valid_in && !is_master && is_ten && !addr_low_phase_in
      && addr_byte_in[7:3] != 5'h1E) |=> !match_out)
    else $error("High byte matched without fixed pattern");
  a_hi_two_bits: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && addr_valid_in && !is_master && is_ten && !addr_low_phase_in
      && addr_byte_in[7:3] == 5'h1E
      && ((addr_byte_in[2:1] ^ divider_r[2:1]) & mask_r[2:1]) == 2'h0)
      |=> match_out)
    else $error("High byte should have matched");
  a_lo_full_byte: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && addr_valid_in && !is_master && is_ten && addr_low_phase_in)
      |=> (match_out == ((($past(addr_byte_in) ^ $past(divider_r))
                          & $past(mask_r)) == 8'h00)))
    else $error("Low byte match wrong");
  a_seven_bit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && addr_valid_in && !is_master && !is_ten)
      |=> (match_out == ((($past(addr_byte_in[7:1]) ^ $past(divider_r[7:1]))
                          & $past(mask_r[7:1])) == 7'h00)))
    else $error("Seven-bit match wrong");
  a_mask_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && addr_valid_in && !is_master && !is_ten && mask_r[7:1] == 7'h00)
      |=> ##0 (match_valid_out && match_out))
    else $error("Masked-off bits blocked a match");
  a_level_ignore: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_dedicated |-> (level_select_out == 2'h0))
    else $error("Level selection leaked to dedicated pins");
  a_buf_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && fifo_valid && !buf_full_r) |=> (buf_full_r
      && data_buffer_r == $past(fifo_data)))
    else $error("Buffer did not take received byte");
endmodule : i2c_address_and_baud_register
`default_nettype wire

// ===== design/i2c_addr_baud_pkg.sv
// Package: register map, field positions and reset values of the port
package i2c_addr_baud_pkg;
  // Register indices on the plain register port
  localparam logic [7:0] ADDR_DIVIDER_OFS = 8'h00; // Address or baud divider
  localparam logic [7:0] ADDRESS_MASK_OFS = 8'h01; // Slave address mask
  localparam logic [7:0] DATA_BUFFER_OFS = 8'h02; // Data buffer
  localparam logic [7:0] PORT_CONTROL_OFS = 8'h03; // Mode control
  localparam logic [7:0] PORT_STATUS_OFS = 8'h04; // Block status
  localparam logic [7:0] LEVEL_SELECT_OFS = 8'h05; // Pin input levels
  // Reset values
  localparam logic [7:0] ADDR_DIVIDER_RST = 8'h00;
  localparam logic [7:0] ADDRESS_MASK_RST = 8'hFF;
  localparam logic [7:0] PORT_CONTROL_RST = 8'h00;
  localparam logic [1:0] LEVEL_SELECT_RST = 2'h0;
  // Control field positions
  localparam int CTRL_MASTER_BIT = 0; // 1 = master, runs the baud divider
  localparam int CTRL_TEN_BIT = 1; // 1 = 10-bit slave address
  localparam int CTRL_DEDICATED_BIT = 2; // 1 = dedicated bus pins in use
  // Status field positions
  localparam int STAT_BUF_FULL_BIT = 0; // Received byte waits in buffer
  localparam int STAT_MATCH_BIT = 1; // Last address byte matched
  localparam int STAT_FIFO_FULL_BIT = 2; // Receive FIFO is full
  localparam int STAT_SCL_BIT = 3; // Present generated clock level
  // Fixed upper pattern of a 10-bit address high byte
  localparam logic [4:0] TEN_BIT_PATTERN = 5'h1E;
  // Receive FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
endpackage : i2c_addr_baud_pkg

// ===== verification/bus_partner.sv
// Far-side bus partner: line pull-ups, address bytes and received bytes
`timescale 1ns/1ns
`default_nettype none
module bus_partner (
  input wire logic sys_clk_in,
  input wire logic scl_oe_in,
  input wire logic rx_ready_in,
  output logic scl_pin_out,
  output logic sda_pin_out,
  output logic addr_valid_out,
  output logic [7:0] addr_byte_out,
  output logic addr_low_phase_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);
  // Clock line is pulled up unless the block pulls it low
  assign scl_pin_out = scl_oe_in ? 1'b0 : 1'b1;
  // Data line is released, so the pull-up holds it high
  assign sda_pin_out = 1'b1;
  initial begin
    addr_valid_out = 1'b0;
    addr_byte_out = 8'h00;
    addr_low_phase_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
  end
  // One address byte as a single-cycle pulse, then a spacer cycle
  task automatic send_addr(input logic [7:0] b, input logic low);
    addr_valid_out <= 1'b1;
    addr_byte_out <= b;
    addr_low_phase_out <= low;
    @(posedge sys_clk_in);
    addr_valid_out <= 1'b0;
    addr_byte_out <= ~b;
    @(posedge sys_clk_in);
  endtask : send_addr
  // One received byte, held until the block takes it
  task automatic send_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge sys_clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    do @(posedge sys_clk_in); while (rx_ready_in !== 1'b1);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b;
  endtask : send_byte
endmodule : bus_partner
`default_nettype wire

// ===== verification/i2c_address_and_baud_register_tb.sv
// Self-checking bench of the address, divider and buffer block
`timescale 1ns/1ns
`default_nettype none
module i2c_address_and_baud_register_tb;
  logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, rd_seen;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, own, msk, b, d;
  logic scl_pin_in, sda_pin_in, scl_oe_out, addr_valid_in, addr_low_phase_in;
  logic match_valid_out, match_out, rx_valid_in, rx_ready_out, tx_load_out;
  logic [7:0] addr_byte_in, rx_data_in, tx_data_out;
  logic [1:0] level_select_out;
  logic ce_in, scl_o_out, scl_sync_out, sda_sync_out; // Enable, pin outputs
  logic [1:0] scl_d, sda_d; // Pin levels two edges back
  logic [7:0] rd_q[$], match_q[$], tx_q[$], rx_sent[17];
  int errors = 0, n_tests = 0, cyc = 0, n, r;
  i2c_address_and_baud_register i2c_address_and_baud_register_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .scl_pin_in(scl_pin_in),
    .sda_pin_in(sda_pin_in), .scl_sync_out(scl_sync_out),
    .sda_sync_out(sda_sync_out),
    .scl_o_out(scl_o_out), .scl_oe_out(scl_oe_out),
    .level_select_out(level_select_out), .addr_valid_in(addr_valid_in),
    .addr_byte_in(addr_byte_in), .addr_low_phase_in(addr_low_phase_in),
    .match_valid_out(match_valid_out), .match_out(match_out),
    .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
    .rx_data_in(rx_data_in), .tx_load_out(tx_load_out),
    .tx_data_out(tx_data_out));
  bus_partner bus_partner_inst (
    .sys_clk_in(sys_clk_in), .scl_oe_in(scl_oe_out),
    .rx_ready_in(rx_ready_out), .scl_pin_out(scl_pin_in),
    .sda_pin_out(sda_pin_in), .addr_valid_out(addr_valid_in),
    .addr_byte_out(addr_byte_in), .addr_low_phase_out(addr_low_phase_in),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in));
  // Compare one value, count it, report a mismatch
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Print the counts and the verdict, then stop
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Bus cycles leave strobes up so they may follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    if (a == i2c_addr_baud_pkg::DATA_BUFFER_OFS) tx_q.push_back(v);
    @(posedge sys_clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    rd_q.push_back(exp);
    @(posedge sys_clk_in);
  endtask : rd
  task automatic idle();
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : idle
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask : do_reset
  // Cycles until the clock pull-down changes level
  task automatic half(output int k);
    logic v;
    v = scl_oe_out;
    k = 0;
    while (scl_oe_out === v && k < 600) begin
      @(posedge sys_clk_in);
      k++;
    end
  endtask : half
  // Own model of the address compare: 0 and 3 seven-bit, 1 high, 2 low
  function automatic logic [7:0] exp_match(input logic [7:0] a,
      input int m, input logic [7:0] o, input logic [7:0] k);
    logic [7:0] x;
    x = (a ^ o) & k;
    if (m == 1) return {7'h0, a[7:3] == 5'b11110 && x[2:1] == 2'b00};
    if (m == 2) return {7'h0, x == 8'h00};
    return {7'h0, x[7:1] == 7'h00};
  endfunction : exp_match
  // Clock of 10 ns
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Hang guard
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // Watcher: takes the oldest note whenever a result shows
  always @(posedge sys_clk_in) begin
    if (rd_seen) check("read data", reg_rdata_out, rd_q.pop_front());
    rd_seen <= reg_rd_in;
    // Synchronised pins lag the pins by two edges
    if (!rst_in) begin
      check("scl sync", {7'h0, scl_sync_out}, {7'h0, scl_d[1]});
      check("sda sync", {7'h0, sda_sync_out}, {7'h0, sda_d[1]});
    end
    scl_d <= {scl_d[0], scl_pin_in};
    sda_d <= {sda_d[0], sda_pin_in};
    if (match_valid_out === 1'b1)
      check("match", {7'h0, match_out}, match_q.size() ? match_q.pop_front() : 8'hxx);
    if (tx_load_out === 1'b1)
      check("tx data", tx_data_out, tx_q.size() ? tx_q.pop_front() : 8'hxx);
  end
  // Main sequence
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    void'($urandom(59162));
    do_reset();
    rd(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, 8'h00);
    rd(i2c_addr_baud_pkg::ADDRESS_MASK_OFS, 8'hFF);
    wr(8'h07, 8'h5A);
    rd(8'h07, 8'h00);
    // Buffer keeps its value through a reset
    d = $urandom;
    wr(i2c_addr_baud_pkg::DATA_BUFFER_OFS, d);
    rd(i2c_addr_baud_pkg::DATA_BUFFER_OFS, d);
    idle();
    do_reset();
    rd(i2c_addr_baud_pkg::DATA_BUFFER_OFS, d);
    rd(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, 8'h00);
    idle();
    // Level selection is dropped on dedicated pins
    wr(i2c_addr_baud_pkg::LEVEL_SELECT_OFS, 8'h03);
    rd(i2c_addr_baud_pkg::LEVEL_SELECT_OFS, 8'h03);
    idle();
    check("level", {6'h0, level_select_out}, 8'h03);
    wr(i2c_addr_baud_pkg::PORT_CONTROL_OFS, 8'h04);
    idle();
    check("level dedicated", {6'h0, level_select_out}, 8'h00);
    check("scl drive", {7'h0, scl_o_out}, 8'h00);
    // A write while the clock enable is low must not land
    ce_in <= 1'b0;
    wr(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, 8'h5A);
    idle();
    ce_in <= 1'b1;
    rd(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, 8'h00);
    // Master clock at the shortest legal divider and a random one
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'(3 + $urandom % 38) : 8'h03;
      wr(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, d);
      wr(i2c_addr_baud_pkg::PORT_CONTROL_OFS, 8'h01);
      idle();
      half(n);
      half(n);
      check("scl half a", 8'(n), 8'(2 * (d + 1)));
      half(n);
      check("scl half b", 8'(n), 8'(2 * (d + 1)));
      bus_partner_inst.send_addr(d, 1'b0);
    end
    // Address compare in every mode, near misses and masked bits
    // Pass 3: seven-bit with every address bit masked off
    for (int m = 0; m < 4; m++) begin
      own = $urandom;
      msk = (m == 3) ? 8'h01 : 8'hFF ^ (8'h01 << ($urandom % 9));
      wr(i2c_addr_baud_pkg::PORT_CONTROL_OFS, m % 3 ? 8'h02 : 8'h00);
      wr(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, own);
      wr(i2c_addr_baud_pkg::ADDRESS_MASK_OFS, msk);
      rd(i2c_addr_baud_pkg::ADDR_DIVIDER_OFS, own);
      rd(i2c_addr_baud_pkg::ADDRESS_MASK_OFS, msk);
      idle();
      for (int i = 0; i < 16; i++) begin
        r = $urandom;
        b = (m == 1) ? {5'b11110, own[2:1], r[8]} : own;
        if (r[1:0] == 2'd1) b = b ^ (8'h01 << r[6:4]);
        if (r[1:0] == 2'd2) b = r[15:8];
        match_q.push_back(exp_match(b, m, own, msk));
        bus_partner_inst.send_addr(b, m == 2);
      end
    end
    // Fill buffer and FIFO until refused, then drain in order
    wr(i2c_addr_baud_pkg::PORT_CONTROL_OFS, 8'h00);
    idle();
    for (int i = 0; i < 17; i++) begin
      rx_sent[i] = $urandom;
      bus_partner_inst.send_byte(rx_sent[i], 1 + $urandom % 3);
    end
    repeat (3) @(posedge sys_clk_in);
    check("fifo refuses", {7'h0, rx_ready_out}, 8'h00);
    // Status: buffer full, last match, FIFO full, clock high
    rd(i2c_addr_baud_pkg::PORT_STATUS_OFS, 8'h0F);
    for (int i = 0; i < 17; i++) begin
      rd(i2c_addr_baud_pkg::DATA_BUFFER_OFS, rx_sent[i]);
      idle();
      repeat (4) @(posedge sys_clk_in);
    end
    // Status after drain: only the match and the clock level remain
    rd(i2c_addr_baud_pkg::PORT_STATUS_OFS, 8'h0A);
    idle();
    repeat (4) @(posedge sys_clk_in);
    check("notes left", 8'(rd_q.size() + match_q.size() + tx_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule : i2c_address_and_baud_register_tb
`default_nettype wire
